//--- redundant_command_decoder.sv
// digital logic of one command decoder: uplink and host receive, time share, execution
//
// Local design decisions: register access over APB and the placing of the registers.

module redundant_command_decoder #(
   parameter int SLOT_CYCLES     = cmd_pkg::SLOT_CYCLES,
   parameter int PULSE_CYCLES    = cmd_pkg::PULSE_CYCLES,
   parameter int SER_HALF_CYCLES = cmd_pkg::SER_HALF_CYCLES
) (
   // clock and reset
   input  wire logic                                 pclk,
   input  wire logic                                 presetn,

   // apb slave
   input  wire logic [11:0]                          paddr,
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [31:0]                          pwdata,
   output logic      [31:0]                          prdata,
   output logic                                      pready,
   output logic                                      pslverr,

   // uplink from the demodulator
   input  wire logic                                 uplink_data,
   input  wire logic                                 recovered_bit_clock,
   input  wire logic                                 carrier_present,

   // host processor serial port
   input  wire logic                                 host_processor_data,
   input  wire logic                                 host_processor_clock,
   input  wire logic                                 host_processor_frame,

   // command outputs
   output logic [cmd_pkg::N_DISCRETE-1:0]            discrete_out,
   output logic [cmd_pkg::N_SERIAL-1:0]              serial_data,
   output logic [cmd_pkg::N_SERIAL-1:0]              serial_clock,
   output logic [cmd_pkg::N_SERIAL-1:0]              serial_envelope,

   // telemetry
   output logic                                      alarm,
   output logic [cmd_pkg::COUNT_W-1:0]               exec_count,
   output logic                                      host_window
);
   // ------------------------------------------------------------
   // local counter widths and end counts
   // ------------------------------------------------------------
   localparam int SW = $clog2(SLOT_CYCLES + 1);
   localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYCLES - 1);

   localparam logic [6:0] UP_LAST   = 7'(cmd_pkg::UP_BITS - 1);
   localparam logic [6:0] HOST_LAST = 7'(cmd_pkg::HOST_BITS - 1);

   // ------------------------------------------------------------
   // pin synchronisers: data, clock, qualifier of both sources
   // ------------------------------------------------------------
   logic [cmd_pkg::N_PINS-1:0] pin_meta;
   logic [cmd_pkg::N_PINS-1:0] pin_sync;
   logic [cmd_pkg::N_PINS-1:0] pin_prev;

   wire  [cmd_pkg::N_PINS-1:0] pin_raw = {host_processor_frame, host_processor_clock,
                                          host_processor_data, carrier_present,
                                          recovered_bit_clock, uplink_data};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // only the edge detectors read pin_prev; both clock pins idle low, so no false edge
   wire up_bit    = pin_sync[0];
   wire up_rise   = pin_sync[1] && !pin_prev[1];
   wire carrier   = pin_sync[2];

   wire host_bit  = pin_sync[3];
   wire host_rise = pin_sync[4] && !pin_prev[4];
   wire host_fr   = pin_sync[5];

   // ------------------------------------------------------------
   // time share slots
   // ------------------------------------------------------------
   cmd_pkg::slot_e  slot;
   cmd_pkg::slot_e  next_slot;

   logic [SW-1:0]   slot_cnt;

   wire             slot_tick = (slot_cnt == '0);

   assign next_slot = (slot == cmd_pkg::SLOT_UPLINK) ? cmd_pkg::SLOT_HOST
                                                     : cmd_pkg::SLOT_UPLINK;

   // fixed alternation is the only arbitration between the two sources
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot     <= cmd_pkg::SLOT_UPLINK;
         slot_cnt <= SLOT_LAST;
      end else begin
         slot_cnt <= slot_tick ? SLOT_LAST : slot_cnt - SW'(1);
         if (slot_tick) slot <= next_slot;
      end
   end

   // the host may shift its bits in while uplink commands run
   assign host_window = (slot == cmd_pkg::SLOT_UPLINK);

   // ------------------------------------------------------------
   // apb registers
   // ------------------------------------------------------------
   logic [cmd_pkg::ADDR_W-1:0] my_addr;
   logic                       disc_en;
   logic                       ser_en;
   logic                       route;
   logic                       pbusy;
   logic                       sbusy;

   wire  hit_ctrl   = (paddr == cmd_pkg::OFF_CTRL);
   wire  hit_status = (paddr == cmd_pkg::OFF_STATUS);
   wire  apb_wr     = psel && penable && pwrite && hit_ctrl;

   wire  [31:0] status_word = {17'h0, sbusy, pbusy, slot, route, ser_en, disc_en,
                               alarm, exec_count};

   // zero wait states; a bad address or a status write answers with an error
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(hit_ctrl || (hit_status && !pwrite));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         my_addr <= cmd_pkg::ADDR_RESET;
         prdata  <= '0;
      end else begin
         if (apb_wr) my_addr <= pwdata[cmd_pkg::ADDR_W-1:0];
         // loaded in setup, so it stands through the whole access
         if (psel && !penable && !pwrite) begin
            prdata <= hit_ctrl   ? {24'h0, my_addr} :
                      hit_status ? status_word      : 32'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // uplink receiver
   // ------------------------------------------------------------
   logic [cmd_pkg::UP_BITS-1:0]    up_sreg;
   logic [6:0]                     up_cnt;
   logic                           up_done;
   logic [cmd_pkg::HOST_BITS-1:0]  up_core;
   logic                           up_pend;

   wire  [cmd_pkg::UP_BITS-1:0]    up_msg  = {up_sreg[cmd_pkg::UP_BITS-2:0], up_bit};

   wire  up_last  = up_rise && (up_cnt == UP_LAST);
   wire  addr_ok  = (up_msg[cmd_pkg::UP_ADDR_LSB +: cmd_pkg::ADDR_W] == my_addr);
   wire  par_ok   = !(^up_msg);

   wire  up_good  = up_last && addr_ok && par_ok;
   wire  up_bad   = up_last && !(addr_ok && par_ok);

   wire  up_exec_go;
   wire  up_taken = up_exec_go;

   // the alarm stops the shifter, so the rest of the transmission is refused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_sreg <= '0;
         up_cnt  <= '0;
         up_done <= 1'b0;
         alarm   <= 1'b0;
      end else if (!carrier) begin
         up_cnt <= '0;
         alarm  <= 1'b0;
      end else if (up_rise && !alarm) begin
         up_sreg <= up_msg;
         up_cnt  <= up_last ? 7'h0 : up_cnt + 7'h1;
         if (up_bad) alarm <= 1'b1;
      end
   end

   // a good message waits for its slot; a later alarm drops it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_core <= '0;
         up_pend <= 1'b0;
      end else if (up_good && !alarm && carrier) begin
         up_core <= up_msg[cmd_pkg::UP_CORE_LSB +: cmd_pkg::HOST_BITS];
         up_pend <= 1'b1;
      end else if (up_taken || alarm) begin
         up_pend <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // host receiver, open only in the uplink slot
   // ------------------------------------------------------------
   logic [cmd_pkg::HOST_BITS-1:0]  host_sreg;
   logic [6:0]                     host_cnt;
   logic [cmd_pkg::HOST_BITS-1:0]  host_core;
   logic                           host_pend;

   wire  host_open = host_window && host_fr && route;
   wire  [cmd_pkg::HOST_BITS-1:0] host_msg = {host_sreg[cmd_pkg::HOST_BITS-2:0], host_bit};

   wire  host_last = host_open && host_rise && (host_cnt == HOST_LAST);

   wire  host_exec_go;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_sreg <= '0;
         host_cnt  <= '0;
      end else if (!host_open) begin
         host_cnt <= '0;                               // a cut-off fragment is dropped
      end else if (host_rise) begin
         host_sreg <= host_msg;
         host_cnt  <= host_last ? 7'h0 : host_cnt + 7'h1;
      end
   end

   // trusted channel: run as received, with no address or parity test
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_core <= '0;
         host_pend <= 1'b0;
      end else if (host_last) begin
         host_core <= host_msg;
         host_pend <= 1'b1;
      end else if (host_exec_go) begin
         host_pend <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // execution at the start of each slot
   // ------------------------------------------------------------
   // one pending command per source per slot pair gives about 33 per second,
   // which covers both command rates; a newer message overwrites an unrun one
   assign up_exec_go   = slot_tick && (next_slot == cmd_pkg::SLOT_UPLINK)
                         && up_pend && !alarm;
   assign host_exec_go = slot_tick && (next_slot == cmd_pkg::SLOT_HOST)
                         && host_pend;

   wire  exec_go = up_exec_go || host_exec_go;
   wire  [cmd_pkg::HOST_BITS-1:0] core = up_exec_go ? up_core : host_core;

   wire  is_special = core[cmd_pkg::KIND_BIT];
   wire  [cmd_pkg::CHAN_W-1:0] chan = core[cmd_pkg::CHAN_LSB +: cmd_pkg::CHAN_W];
   wire  [cmd_pkg::SER_BITS-1:0] payload = core[cmd_pkg::SER_BITS-1:0];
   wire  [cmd_pkg::SEL_W-1:0] disc_sel = payload[cmd_pkg::SEL_W-1:0];
   wire  [cmd_pkg::SUBOP_W-1:0] subop_raw = payload[cmd_pkg::SUBOP_LSB +: cmd_pkg::SUBOP_W];

   cmd_pkg::subop_e subop;
   assign subop = cmd_pkg::subop_e'(subop_raw);
   wire  sub_val = payload[cmd_pkg::SUBOP_VAL];

   // the low discretes are never gated, so they work before any enable
   wire  disc_gated = (disc_sel >= cmd_pkg::SEL_W'(cmd_pkg::FIRST_GATED));

   wire  do_pulse = exec_go && is_special && (subop == cmd_pkg::SUB_PULSE)
                    && (!disc_gated || disc_en);

   // a serial command to an absent channel or a busy shifter is lost
   wire  do_serial = exec_go && !is_special && ser_en && !sbusy
                     && (chan < cmd_pkg::CHAN_W'(cmd_pkg::N_SERIAL));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disc_en    <= 1'b0;
         ser_en     <= 1'b0;
         route      <= 1'b1;
         exec_count <= '0;
      end else begin
         // counted at execution, so a dropped message never counts
         if (up_exec_go) exec_count <= exec_count + cmd_pkg::COUNT_W'(1);

         if (exec_go && is_special) begin
            unique case (subop)
               cmd_pkg::SUB_PULSE:  ;
               cmd_pkg::SUB_DISCEN: disc_en <= sub_val;
               cmd_pkg::SUB_SEREN:  ser_en  <= sub_val;
               cmd_pkg::SUB_ROUTE:  route   <= sub_val;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // output units
   // ------------------------------------------------------------
   exec_if pulse_req ();
   exec_if serial_req ();

   assign pulse_req.start    = do_pulse;
   assign pulse_req.sel      = disc_sel;
   assign pulse_req.payload  = payload;
   assign pbusy              = pulse_req.busy;

   assign serial_req.start   = do_serial;
   assign serial_req.sel     = cmd_pkg::SEL_W'(chan);
   assign serial_req.payload = payload;
   assign sbusy              = serial_req.busy;

   // a new start restarts the pulser; the shifter refuses one while busy
   discrete_pulser #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulser (
      .pclk         (pclk),
      .presetn      (presetn),
      .cmd          (pulse_req.unit),
      .discrete_out (discrete_out)
   );

   serial_shifter #(.HALF_CYCLES(SER_HALF_CYCLES)) u_serial (
      .pclk            (pclk),
      .presetn         (presetn),
      .cmd             (serial_req.unit),
      .serial_data     (serial_data),
      .serial_clock    (serial_clock),
      .serial_envelope (serial_envelope)
   );
endmodule

//--- cmd_pkg.sv
// constants, field layouts and types shared by the command decoder files
package cmd_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ          = 40_000_000;
   localparam int SLOT_MS         = 15;
   localparam int SLOT_CYCLES     = CLK_HZ / 1000 * SLOT_MS;
   localparam int PULSE_MS        = 15;
   localparam int PULSE_CYCLES    = CLK_HZ / 1000 * PULSE_MS;
   localparam int SER_CLK_DHZ     = 42700;   // 4.27 kHz in tenths of a hertz
   localparam int SER_HALF_CYCLES = CLK_HZ * 10 / (2 * SER_CLK_DHZ);
   // ------------------------------------------------------------
   // output counts and message sizes
   // ------------------------------------------------------------
   localparam int N_DISCRETE  = 128;
   localparam int N_GATED     = 96;
   localparam int FIRST_GATED = N_DISCRETE - N_GATED;
   localparam int N_SERIAL    = 48;
   localparam int SER_BITS    = 37;
   localparam int UP_BITS     = 60;
   localparam int HOST_BITS   = 44;
   localparam int COUNT_W     = 8;
   localparam int ADDR_W      = 8;
   localparam int SEL_W       = 7;
   localparam int CHAN_W      = 6;
   localparam int BITCNT_W    = 6;
   // ------------------------------------------------------------
   // message fields: a 44-bit core, wrapped by address and parity uplink
   // ------------------------------------------------------------
   localparam int UP_ADDR_LSB = 52;
   localparam int UP_CORE_LSB = 8;
   localparam int KIND_BIT    = 43;
   localparam int CHAN_LSB    = 37;
   localparam int SUBOP_LSB   = 7;
   localparam int SUBOP_W     = 2;
   localparam int SUBOP_VAL   = 9;
   typedef enum logic [1:0] {
      SUB_PULSE  = 2'h0,
      SUB_DISCEN = 2'h1,
      SUB_SEREN  = 2'h2,
      SUB_ROUTE  = 2'h3
   } subop_e;
   typedef enum logic {
      SLOT_UPLINK = 1'b0,
      SLOT_HOST   = 1'b1
   } slot_e;
   // ------------------------------------------------------------
   // apb map
   // ------------------------------------------------------------
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h5a;  // arbitrary default
   localparam int ST_ALARM  = 8;
   localparam int ST_DISCEN = 9;
   localparam int ST_SEREN  = 10;
   localparam int ST_ROUTE  = 11;
   localparam int ST_SLOT   = 12;
   localparam int ST_PBUSY  = 13;
   localparam int ST_SBUSY  = 14;
   localparam int N_PINS    = 6;
endpackage

//--- exec_if.sv
// start request and busy answer between the decoder and an output unit
interface exec_if;
   logic                             start;
   logic [cmd_pkg::SEL_W-1:0]        sel;
   logic [cmd_pkg::SER_BITS-1:0]     payload;
   logic                             busy;
   modport ctrl (output start, output sel, output payload, input busy);
   modport unit (input start, input sel, input payload, output busy);
endinterface

//--- discrete_pulser.sv
// one-of-128 discrete pulse generator
module discrete_pulser #(
   parameter int PULSE_CYCLES = cmd_pkg::PULSE_CYCLES
) (
   // clock and reset
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   // request
   exec_if.unit                                   cmd,
   // outputs
   output logic [cmd_pkg::N_DISCRETE-1:0]         discrete_out
);
   localparam int CW = $clog2(PULSE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);
   logic [CW-1:0] count;
   wire  [cmd_pkg::N_DISCRETE-1:0] onehot = cmd_pkg::N_DISCRETE'(1) << cmd.sel;

   assign cmd.busy = |discrete_out;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         discrete_out <= '0;
         count        <= '0;
      end else if (cmd.start) begin
         discrete_out <= onehot;
         count        <= LAST;
      end else if (cmd.busy) begin
         if (count == '0) discrete_out <= '0;
         else count <= count - CW'(1);
      end
   end
endmodule

//--- serial_shifter.sv
// addressed 37-bit serial command output with clock and envelope
module serial_shifter #(
   parameter int HALF_CYCLES = cmd_pkg::SER_HALF_CYCLES
) (
   // clock and reset
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   // request
   exec_if.unit                                   cmd,
   // outputs
   output logic [cmd_pkg::N_SERIAL-1:0]           serial_data,
   output logic [cmd_pkg::N_SERIAL-1:0]           serial_clock,
   output logic [cmd_pkg::N_SERIAL-1:0]           serial_envelope
);
   localparam int DW = $clog2(HALF_CYCLES + 1);
   localparam logic [DW-1:0] DLAST = DW'(HALF_CYCLES - 1);
   localparam logic [cmd_pkg::BITCNT_W-1:0] BLAST = cmd_pkg::BITCNT_W'(cmd_pkg::SER_BITS - 1);
   logic [DW-1:0]                     div;
   logic [cmd_pkg::SER_BITS-1:0]      sreg;
   logic [cmd_pkg::BITCNT_W-1:0]      bits;
   logic [cmd_pkg::CHAN_W-1:0]        chan;
   logic                              env;
   logic                              clk_lvl;
   wire                               tick = env && (div == '0);

   assign cmd.busy = env;

   // ------------------------------------------------------------
   // shift sequence, msb first, data changes on the falling edge
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div     <= '0;
         sreg    <= '0;
         bits    <= '0;
         chan    <= '0;
         env     <= 1'b0;
         clk_lvl <= 1'b0;
      end else if (cmd.start && !env) begin
         div     <= DLAST;
         sreg    <= cmd.payload;
         bits    <= '0;
         chan    <= cmd.sel[cmd_pkg::CHAN_W-1:0];
         env     <= 1'b1;
         clk_lvl <= 1'b0;
      end else if (env) begin
         div <= tick ? DLAST : div - DW'(1);
         if (tick) begin
            clk_lvl <= !clk_lvl;
            if (clk_lvl) begin
               if (bits == BLAST) env <= 1'b0;
               else begin
                  bits <= bits + cmd_pkg::BITCNT_W'(1);
                  sreg <= {sreg[cmd_pkg::SER_BITS-2:0], 1'b0};
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // only the addressed channel moves; the rest sit low
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < cmd_pkg::N_SERIAL; i++) begin : g_ch
         wire hit = env && (chan == cmd_pkg::CHAN_W'(i));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               serial_data[i]     <= 1'b0;
               serial_clock[i]    <= 1'b0;
               serial_envelope[i] <= 1'b0;
            end else begin
               serial_data[i]     <= hit && sreg[cmd_pkg::SER_BITS-1];
               serial_clock[i]    <= hit && clk_lvl;
               serial_envelope[i] <= hit;
            end
         end
      end
   endgenerate
endmodule

//--- decoder_props.sv
// concurrent checks on the command decoder ports
module decoder_props #(
   parameter int SLOT_CYCLES  = 2000,
   parameter int PULSE_CYCLES = 1500
) (
   // clock and reset
   input wire logic         pclk,
   input wire logic         presetn,
   // watched pins
   input wire logic         carrier_present,
   input wire logic [127:0] discrete_out,
   input wire logic [47:0]  serial_clock,
   input wire logic [47:0]  serial_envelope,
   input wire logic         alarm,
   input wire logic [7:0]   exec_count,
   input wire logic         host_window
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   int   pcnt;
   int   scnt;
   logic seen;
   // the first slot after reset is skipped: its start is not a boundary
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcnt <= 0;
         scnt <= 0;
         seen <= 1'b0;
      end else begin
         pcnt <= (|discrete_out) ? pcnt + 1 : 0;
         scnt <= $changed(host_window) ? 0 : scnt + 1;
         seen <= seen | $changed(host_window);
      end
   end
   a_pulse_len: assert property ($fell(|discrete_out) |-> pcnt == PULSE_CYCLES)
      else $error("discrete pulse length wrong");
   a_disc_onehot: assert property ($onehot0(discrete_out))
      else $error("more than one discrete high");
   a_ser_onechan: assert property ($onehot0(serial_envelope))
      else $error("more than one serial channel active");
   a_ser_idle: assert property ((serial_clock & ~serial_envelope) == '0)
      else $error("serial clock outside envelope");
   a_count_step: assert property ($changed(exec_count) |-> exec_count == $past(exec_count) + 8'h01)
      else $error("execution count did not step by one");
   a_count_alarm: assert property (alarm |=> $stable(exec_count))
      else $error("uplink executed under alarm");
   a_alarm_hold: assert property (alarm && carrier_present && $past(carrier_present)
      && $past(carrier_present, 2) && $past(carrier_present, 3) |=> alarm)
      else $error("alarm cleared with carrier present");
   a_slot_len: assert property ($changed(host_window) && seen |-> scnt == SLOT_CYCLES - 1)
      else $error("time-share slot length wrong");
endmodule
bind redundant_command_decoder decoder_props #(.SLOT_CYCLES(SLOT_CYCLES),
   .PULSE_CYCLES(PULSE_CYCLES)) props (.pclk, .presetn, .carrier_present, .discrete_out,
   .serial_clock, .serial_envelope, .alarm, .exec_count, .host_window);

//--- link_partner.sv
// far-side model: demodulator pins and host processor serial port
module link_partner (
   // clock
   input  wire logic pclk,
   // uplink and host pins
   output logic      uplink_data,
   output logic      recovered_bit_clock,
   output logic      carrier_present,
   output logic      host_processor_data,
   output logic      host_processor_clock,
   output logic      host_processor_frame
);
   timeunit 1ns / 1ps;
   initial {uplink_data, recovered_bit_clock, carrier_present} = '0;
   initial {host_processor_data, host_processor_clock, host_processor_frame} = '0;
   // msb first, 225 ns bit period; both sources feed this one decoder
   task automatic send(input logic [59:0] m, input int n, input logic host);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge pclk);
         if (host) {host_processor_frame, host_processor_data} <= {1'b1, m[i]};
         else {carrier_present, uplink_data} <= {1'b1, m[i]};
         repeat (4) @(posedge pclk);
         if (host) host_processor_clock <= 1'b1;
         else recovered_bit_clock <= 1'b1;
         repeat (4) @(posedge pclk);
         {host_processor_clock, recovered_bit_clock} <= 2'b00;
      end
      @(posedge pclk);
      host_processor_frame <= 1'b0;
      // released lines flip so a stale bit is never read as valid
      {host_processor_data, uplink_data} <= ~{host_processor_data, uplink_data};
   endtask
endmodule

//--- testbench.sv
// self-checking bench: apb, host and uplink commands against the decoder
module testbench;
   timeunit 1ns / 1ps;
   localparam int SLOT = 2000, PULSE = 1500, HALF = 20;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pc = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [127:0] discrete_out;
   logic [47:0] serial_data, serial_clock, serial_envelope;
   logic [7:0] exec_count, addr;
   logic [59:0] msg;
   logic [36:0] pay, got;
   logic pready, pslverr, err, alarm, host_window, uplink_data, recovered_bit_clock;
   logic carrier_present, host_processor_data, host_processor_clock, host_processor_frame;
   int error_cnt = 0, n_compared = 0, ch, k, t0, t1;
   always #12.5 pclk = ~pclk;
   redundant_command_decoder #(.SLOT_CYCLES(SLOT), .PULSE_CYCLES(PULSE),
      .SER_HALF_CYCLES(HALF)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .uplink_data, .recovered_bit_clock,
      .carrier_present, .host_processor_data, .host_processor_clock,
      .host_processor_frame, .discrete_out, .serial_data, .serial_clock,
      .serial_envelope, .alarm, .exec_count, .host_window);
   link_partner P (.pclk, .uplink_data, .recovered_bit_clock, .carrier_present,
      .host_processor_data, .host_processor_clock, .host_processor_frame);
   task automatic check(string s, logic [127:0] e, logic [127:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   function automatic logic [43:0] spec(logic [1:0] op, logic v, logic [6:0] a);
      return {1'b1, 33'h0, v, op, a};
   endfunction
   function automatic logic [59:0] upmsg(logic [7:0] ad, logic [43:0] c);
      logic [59:0] m;
      m = {ad, c, 8'h00};
      m[0] = ^m;
      return m;
   endfunction
   // host bits must go in while the uplink slot runs
   task automatic host(logic [43:0] c);
      @(posedge host_window);
      P.send({16'h0000, c}, 44, 1'b1);
      @(negedge host_window);
      @(negedge pclk);
   endtask
   task automatic pulse(int idx, logic on);
      int n;
      for (n = 0; n < 5000 && discrete_out[idx] !== 1'b1; n++) @(negedge pclk);
      check("pulse sel", on ? 128'h1 << idx : '0, discrete_out);
      for (n = 0; discrete_out[idx] === 1'b1 && n < 3000; n++) @(negedge pclk);
      check("pulse len", on ? PULSE : 0, n);
   endtask
   initial begin
      repeat (90000) @(posedge pclk);
      error_cnt++;
      complete_run();
   end
   initial begin
      void'($urandom(31297));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h004, '0);
      check("status", 32'h800, rd);
      apb(1'b0, 12'h008, '0);
      check("slverr", 1'b1, err);
      addr = 8'($urandom);
      apb(1'b1, 12'h000, {24'h0, addr});
      apb(1'b0, 12'h000, '0);
      check("ctrl", addr, rd[7:0]);
      host(spec(2'h0, 1'b0, 7'h28));
      pulse(40, 1'b0);
      host(spec(2'h1, 1'b1, 7'h00));
      host(spec(2'h0, 1'b0, 7'h28));
      pulse(40, 1'b1);
      host(spec(2'h2, 1'b1, 7'h00));
      ch = $urandom_range(47);
      pay = 37'({$urandom, $urandom});
      host({1'b0, ch[5:0], pay});
      k = 0;
      for (int i = 0; i < 4000 && k < 37; i++) begin
         @(negedge pclk);
         if (serial_clock[ch] && !pc) begin
            if (k == 0) t0 = i;
            got = {got[35:0], serial_data[ch]};
            k++;
            t1 = i;
         end
         pc = serial_clock[ch];
      end
      check("serial bits", pay, got);
      check("serial rate", 72 * HALF, t1 - t0);
      msg = upmsg(addr, spec(2'h0, 1'b0, 7'h05));
      P.send(msg, 60, 1'b0);
      pulse(5, 1'b1);
      check("count", 8'h01, exec_count);
      for (int e = 0; e < 2; e++) begin
         P.send(e ? upmsg(~addr, spec(2'h0, 1'b0, 7'h06)) : msg ^ 60'h1, 60, 1'b0);
         repeat (5) @(negedge pclk);
         check("alarm set", 1'b1, alarm);
         P.send(msg, 60, 1'b0);
         pulse(5, 1'b0);
         check("count held", 8'h01, exec_count);
         @(posedge pclk);
         P.carrier_present <= 1'b0;
         repeat (8) @(negedge pclk);
         check("alarm clear", 1'b0, alarm);
      end
      complete_run();
   end
endmodule
